/* hdl/rrw_top.sv */
// Purpose: builds receive subaddress records in shared ram
// Assumes: a decoder upstream presents commands, words and end of message
// Notes: the ram is local and read by software over apb
// Summary of operation
// - broadcast receive data goes to separate buffer
// - circular modes never segregate broadcast data
// - info and time-tag words precede data
// - on error only info and time-tag written
// - message fault set on bits 7, 11-15
// - data pointer addresses the info word
// - invalid word flag on manchester or parity
// - gap flag on extra activity or early gap
// - short count flag on too few words
// - sync type flag on command sync data
// - answered busy flag, data still buffered
// - illegal command flag from illegalization entry
// - second command word checks set transmitter fault
// - bad transmitter status sets transmitter fault
// - terminal to terminal flag on clean transfer
// - bus select flag zero a, one b
// - word count field copied, zero means 32
// - time tag captured at command validation
`timescale 1ns/100ps
module rrw_top (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // command from decoder, validated when cmd_valid pulses
  input wire logic cmd_valid,
  input wire rrw_pkg::rrw_cmd_t cmd,
  // terminal-to-terminal status from transmitter
  input wire logic tx_status_valid,
  input wire logic [15:0] tx_status,
  input wire logic tx_status_bad,
  // received data words
  input wire logic word_valid,
  input wire rrw_pkg::rrw_word_t word,
  // bus events
  input wire logic gap_seen,
  input wire logic extra_activity,
  input wire logic msg_end,
  // record done pulse
  output logic record_done,
  output logic [15:0] last_info
);
  import rrw_pkg::*;
  // record layout from the chosen base:
  //   base + 0  info word, written last
  //   base + 1  time tag at validation
  //   base + 2  data words in arrival order
  // a faulted record gets the two header words only;
  // its data area keeps what an earlier record left
  // words beyond the expected count are dropped
  // broadcast separation picks the second pointer
  // for indexed and ping-pong buffers only
  // the timeout counter lives in a submodule
  // all outputs come straight from flip-flops
  // record state machine; stat shows its code
  // so software can tell a record in progress
  typedef enum logic [1:0] {
    RRW_IDLE = 2'b00,
    RRW_RECV = 2'b01,
    RRW_TAG = 2'b10,
    RRW_INFO = 2'b11
  } rrw_state_t;
  rrw_state_t state;
  logic [15:0] mem [0:(1 << `RRW_MEM_AW) - 1]; // shared ram
  logic [3:0] ctrl; // control register
  logic [15:0] time_tag; // free running tag counter
  logic [15:0] tag_hold; // tag at validation
  rrw_cmd_t held; // command under way
  logic [8:0] base; // record start
  logic [5:0] got; // data words received
  logic [5:0] want; // expected words
  logic [15:0] flags; // error and status bits
  // ram write port, driven by one process
  logic wr_en; // one ram write port
  logic [8:0] wr_addr;
  logic [15:0] wr_data;
  // timeout submodule handshake
  logic tmo_start;
  logic tmo_fired;
  logic [15:0] info_word;
  // apb phase strobes
  logic apb_setup;
  logic apb_wr;
  // staging holds one message; a fault seen at the
  // last word must still keep every word out of ram
  logic [15:0] stage [0:31]; // data held until clean
  logic [5:0] copied; // staged words moved to ram
  // expected word count; zero field means 32
  // the count tops at 32, so six bits suffice
  function automatic logic [5:0] expected(input logic [15:0] cw);
    expected = (cw[4:0] == 5'h00) ? 6'd32 : {1'b0, cw[4:0]};
  endfunction
  // second command word checks: broadcast target, receive
  // direction, mode-code subaddress or the receiver's own
  // address mark the transmitter faulty before any word
  function automatic logic cw2_fault(input logic [15:0] cw1, input logic [15:0] cw2);
    cw2_fault = (cw2[15:11] == `RRW_BCAST_RT) || !cw2[10] ||
                (cw2[9:5] == 5'h00) || (cw2[9:5] == 5'h1f) ||
                (cw2[15:11] == cw1[15:11]);
  endfunction
  // apb phase decode; every setup is answered next cycle
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  // choice of base: only indexed or ping-pong may separate
  // circular modes keep one buffer, shared by broadcast
  function automatic logic [8:0] pick_base(input rrw_cmd_t c, input logic bsep);
    if (bsep && c.broadcast && (c.buf_mode == RRW_BUF_INDEXED || c.buf_mode == RRW_BUF_PINGPONG))
      pick_base = c.bcast_pointer;
    else
      pick_base = c.data_pointer;
  endfunction
  // time tag counter, free running
  // wraps at 16 bits; software reads it at the ttag offset
  // and the sequencer copies it when a command is validated
  // no load from software, only presetn clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      time_tag <= 16'h0000;
    else
      time_tag <= time_tag + 16'h0001;
  end
  // control register written by software
  // bit 0 broadcast separation, 2:1 timeout select, 3 busy
  // bits above 3 are dropped and read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl <= `RRW_CTRL_RST;
    else if (apb_wr && paddr == `RRW_OFS_CTRL)
      ctrl <= pwdata[3:0];
  end
  // timeout only armed for terminal-to-terminal commands
  // a plain receive waits for no transmitter; a flag left
  // from an earlier message is masked by held.rt_to_rt
  // it stops as soon as the transmitter's status arrives
  assign tmo_start = cmd_valid && state == RRW_IDLE && cmd.rt_to_rt;
  rrw_timeout u_timeout (
    .pclk(pclk),
    .presetn(presetn),
    .start(tmo_start),
    .stop(tx_status_valid),
    .timeout_select(ctrl[`RRW_CTRL_TOSEL_LO +: 2]),
    .fired(tmo_fired)
  );
  // info word assembly; combinational, so the header
  // always shows the final flags of the record
  always_comb begin
    info_word = flags;
    // timeout bit comes latched from the sequencer
    // short count from the words actually taken
    info_word[`RRW_IW_WCT] = flags[`RRW_IW_WCT] | (got < want);
    // message fault collects every error bit
    info_word[`RRW_IW_MESSAGE_FAULT_FLAG] = info_word[`RRW_IW_TMO] | info_word[`RRW_IW_IWD] |
                              info_word[`RRW_IW_GAP] | info_word[`RRW_IW_WCT] |
                              info_word[`RRW_IW_SYN] | info_word[`RRW_IW_TXRT];
    // clean transfer flag only without any fault
    info_word[`RRW_IW_TERMINAL_TO_TERMINAL_FLAG] = held.rt_to_rt & !info_word[`RRW_IW_MESSAGE_FAULT_FLAG];
    // bus and word count copied as received
    info_word[`RRW_IW_BUS] = held.bus_b;
    info_word[4:0] = held.first_command_word[4:0];
  end
  // record sequencer
  // idle: wait for a command, latch it with the time tag
  // recv: gather words into staging, collect fault flags
  // tag: copy staged words if clean, then the time tag
  // info: write the info word at the record start
  // flags are only set in a record, cleared at its start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= RRW_IDLE;
      held <= '0;
      base <= 9'h000;
      got <= 6'd0;
      want <= 6'd0;
      flags <= 16'h0000;
      tag_hold <= 16'h0000;
      copied <= 6'd0;
    end else begin
      case (state)
        RRW_IDLE: begin
          // a command while busy is ignored
          if (cmd_valid) begin
            held <= cmd;
            base <= pick_base(cmd, ctrl[`RRW_CTRL_BSEP]);
            tag_hold <= time_tag;
            got <= 6'd0;
            copied <= 6'd0;
            want <= expected(cmd.first_command_word);
            flags <= 16'h0000;
            // busy and illegal come with the command
            flags[`RRW_IW_BSY] <= cmd.make_busy_control | ctrl[`RRW_CTRL_BUSY];
            flags[`RRW_IW_ILL] <= cmd.illegal;
            flags[`RRW_IW_TXRT] <= cmd.rt_to_rt &&
                                   cw2_fault(cmd.first_command_word, cmd.second_command_word);
            state <= RRW_RECV;
          end
        end
        RRW_RECV: begin
          // status check of transmitting terminal
          // wrong address or a bad status word both count
          if (tx_status_valid && held.rt_to_rt &&
              (tx_status_bad || tx_status[15:11] != held.second_command_word[15:11]))
            flags[`RRW_IW_TXRT] <= 1'b1;
          // received data words
          if (word_valid) begin
            // parity or manchester fault on this word
            if (word.bad)
              flags[`RRW_IW_IWD] <= 1'b1;
            // command sync where data sync belongs
            if (word.cmd_sync)
              flags[`RRW_IW_SYN] <= 1'b1;
            // words past the count are dropped
            if (got < want)
              got <= got + 6'd1;
          end
          // gap before all words, or activity after last
          if ((gap_seen && got < want) || (extra_activity && got >= want))
            flags[`RRW_IW_GAP] <= 1'b1;
          // leave on end of message, or when the transmitter
          // never started; the latch keeps a later fire out
          if (msg_end || (held.rt_to_rt && tmo_fired)) begin
            state <= RRW_TAG;
            if (held.rt_to_rt && tmo_fired)
              flags[`RRW_IW_TMO] <= 1'b1;
          end
        end
        RRW_TAG: begin
          // one staged word per cycle while the record is clean
          if (!info_word[`RRW_IW_MESSAGE_FAULT_FLAG] && copied < got)
            copied <= copied + 6'd1;
          else
            state <= RRW_INFO;
        end
        RRW_INFO: begin
          // header complete
          state <= RRW_IDLE;
        end
        default: begin
          // unused codes recover to idle
          state <= RRW_IDLE;
        end
      endcase
    end
  end
  // staging buffer; no reset, each word is written before read
  // got never passes 31 while a word is stored
  always_ff @(posedge pclk) begin
    if (state == RRW_RECV && word_valid && got < want)
      stage[got[4:0]] <= word.data;
  end
  // single ram write port; data first, header words last
  // the copy runs in the tag state, once the verdict is known
  always_comb begin
    wr_en = 1'b0;
    wr_addr = 9'h000;
    wr_data = 16'h0000;
    if (state == RRW_TAG && !info_word[`RRW_IW_MESSAGE_FAULT_FLAG] && copied < got) begin
      // staged data, only for a clean record
      wr_en = 1'b1;
      wr_addr = base + 9'd2 + {3'b000, copied};
      wr_data = stage[copied[4:0]];
    end else if (state == RRW_TAG) begin
      // time tag once copying is done
      wr_en = 1'b1;
      wr_addr = base + 9'd1;
      wr_data = tag_hold;
    end else if (state == RRW_INFO) begin
      // info word last: a poller sees a finished record
      wr_en = 1'b1;
      wr_addr = base;
      wr_data = info_word;
    end
  end
  // shared ram; one write port, one read port for apb
  // reads happen in setup only, so no arbitration is needed
  always_ff @(posedge pclk) begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
  end
  // done pulse and last info word
  // record_done pulses one cycle, after the info write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      record_done <= 1'b0;
      last_info <= 16'h0000;
    end else begin
      record_done <= state == RRW_INFO;
      // captured with the info write
      if (state == RRW_INFO)
        last_info <= info_word;
    end
  end
  // apb: zero wait states, reads registered in setup
  // prdata is taken in setup, so it stands with pready;
  // writes to anything but control are refused with
  // pslverr, as are reads outside the map
  // stat packs the state code above the last info word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // pready stands only in the access cycle
      pready <= apb_setup;
      pslverr <= 1'b0;
      // read decode
      if (apb_setup && !pwrite) begin
        if (paddr == `RRW_OFS_CTRL)
          prdata <= {28'h0000000, ctrl};
        else if (paddr == `RRW_OFS_STAT)
          prdata <= {14'h0000, state, last_info};
        else if (paddr == `RRW_OFS_TTAG)
          prdata <= {16'h0000, time_tag};
        else if (paddr[11] && paddr[1:0] == 2'b00)
          prdata <= {16'h0000, mem[paddr[10:2]]};
        else begin
          prdata <= 32'h0000_0000;
          pslverr <= 1'b1; // unmapped read
        end
      end else if (apb_setup && pwrite) begin
        // writes carry no read data
        prdata <= 32'h0000_0000;
        pslverr <= !(paddr == `RRW_OFS_CTRL);
      end
    end
  end
endmodule

/* shared/rrw_defs.svh */
// Purpose: offsets, field positions, reset values and counts for the receive record writer
// Assumes: included by bare name from the package only; the design files use its macros without including it
// Notes: register offsets are byte addresses on a 32-bit apb bus
`ifndef RRW_DEFS_SVH
`define RRW_DEFS_SVH
// register byte offsets
`define RRW_OFS_CTRL 12'h000
`define RRW_OFS_STAT 12'h004
`define RRW_OFS_TTAG 12'h008
`define RRW_OFS_MEM 12'h800
// control field positions
`define RRW_CTRL_BSEP 0
`define RRW_CTRL_TOSEL_LO 1
`define RRW_CTRL_BUSY 3
// information word field positions
`define RRW_IW_TMO 15
`define RRW_IW_IWD 14
`define RRW_IW_GAP 13
`define RRW_IW_WCT 12
`define RRW_IW_SYN 11
`define RRW_IW_MESSAGE_FAULT_FLAG 10
`define RRW_IW_BSY 9
`define RRW_IW_ILL 8
`define RRW_IW_TXRT 7
`define RRW_IW_TERMINAL_TO_TERMINAL_FLAG 6
`define RRW_IW_BUS 5
// reset values
`define RRW_CTRL_RST 4'h0
// response timeouts in cycles of 5 ns: 15, 20, 50, 130 us
`define RRW_TMO_0 16'd3000
`define RRW_TMO_1 16'd4000
`define RRW_TMO_2 16'd10000
`define RRW_TMO_3 16'd26000
// record geometry
`define RRW_MEM_AW 9
`define RRW_REC_WORDS 6'd34
`define RRW_BCAST_RT 5'h1f
`endif

/* shared/rrw_pkg.sv */
// Purpose: shared types of the receive record writer
// Assumes: rrw_defs.svh holds the numbers
// Notes: none
package rrw_pkg;
  `include "rrw_defs.svh"
  // buffering method of a subaddress
  typedef enum logic [1:0] {
    RRW_BUF_INDEXED = 2'b00,
    RRW_BUF_PINGPONG = 2'b01,
    RRW_BUF_CIRC1 = 2'b10,
    RRW_BUF_CIRC2 = 2'b11
  } rrw_buf_t;
  // command presented by the decoder
  typedef struct packed {
    logic [15:0] first_command_word;
    logic [15:0] second_command_word;
    logic rt_to_rt;
    logic broadcast;
    logic bus_b;
    logic illegal;
    logic make_busy_control;
    rrw_buf_t buf_mode;
    logic [8:0] data_pointer;
    logic [8:0] bcast_pointer;
  } rrw_cmd_t;
  // received word event
  typedef struct packed {
    logic [15:0] data;
    logic cmd_sync;
    logic bad;
  } rrw_word_t;
endpackage

/* hdl/rrw_timeout.sv */
// Purpose: response timeout counter for terminal-to-terminal receive
// Assumes: start pulses when the second command word ends, stop when status begins
// Notes: a fired flag holds until the next start
`timescale 1ns/100ps
module rrw_timeout (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic [1:0] timeout_select,
  // result
  output logic fired
);
  import rrw_pkg::*;
  logic [15:0] count; // cycles left
  logic running; // waiting for the transmitter
  // limit chosen per select code
  function automatic logic [15:0] limit(input logic [1:0] sel);
    case (sel)
      2'd0: limit = `RRW_TMO_0;
      2'd1: limit = `RRW_TMO_1;
      2'd2: limit = `RRW_TMO_2;
      default: limit = `RRW_TMO_3;
    endcase
  endfunction
  // countdown and fire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 16'h0000;
      running <= 1'b0;
      fired <= 1'b0;
    end else if (start) begin
      count <= limit(timeout_select);
      running <= 1'b1;
      fired <= 1'b0;
    end else if (running && stop) begin
      running <= 1'b0;
    end else if (running && count == 16'h0001) begin
      running <= 1'b0;
      fired <= 1'b1;
    end else if (running) begin
      count <= count - 16'h0001;
    end
  end
endmodule

/* bench/rrw_top_chk.sv */
// Purpose: port checks of the receive record writer
// Assumes: one clock domain, presetn async low
// Notes: command fields are held from validation to record_done
`timescale 1ns/100ps
module rrw_top_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // decoder side
  input wire logic cmd_valid,
  input wire rrw_pkg::rrw_cmd_t cmd,
  input wire logic tx_status_valid,
  input wire logic [15:0] tx_status,
  input wire logic tx_status_bad,
  input wire logic word_valid,
  input wire rrw_pkg::rrw_word_t word,
  input wire logic gap_seen,
  input wire logic extra_activity,
  input wire logic msg_end,
  // results
  input wire logic record_done,
  input wire logic [15:0] last_info
);
  import rrw_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic open;  // record in progress
  rrw_cmd_t held;  // its command
  // capture the command at validation, only when idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open <= 1'b0;
      held <= '0;
    end else if (cmd_valid && !open) begin
      open <= 1'b1;
      held <= cmd;
    end else if (record_done) begin
      open <= 1'b0;
    end
  end
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no pready after setup");
  property p_short; pready |=> !pready; endproperty
  a_short: assert property (p_short) else $error("pready held too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_message_fault_flag; last_info[10] == (|last_info[15:11] || last_info[7]); endproperty
  a_message_fault_flag: assert property (p_message_fault_flag) else $error("fault summary wrong");
  property p_terminal_to_terminal_flag; last_info[6] |-> !last_info[10]; endproperty
  a_terminal_to_terminal_flag: assert property (p_terminal_to_terminal_flag) else $error("rt-rt flag on faulted record");
  property p_wc; record_done |-> last_info[4:0] == held.first_command_word[4:0]; endproperty
  a_wc: assert property (p_wc) else $error("word count field wrong");
  property p_bus; record_done |-> last_info[5] == held.bus_b && last_info[8] == held.illegal; endproperty
  a_bus: assert property (p_bus) else $error("bus or illegal flag wrong");
  property p_bsy; record_done && held.make_busy_control |-> last_info[9]; endproperty
  a_bsy: assert property (p_bsy) else $error("busy flag missing");
  property p_txrt; record_done && held.rt_to_rt && !held.second_command_word[10] |-> last_info[7]; endproperty
  a_txrt: assert property (p_txrt) else $error("transmitter fault missing");
  property p_end; open && msg_end |-> ##[3:35] record_done; endproperty
  a_end: assert property (p_end) else $error("record not closed");
  c_fault: cover property (record_done && last_info[10]);
  c_terminal_to_terminal_flag: cover property (record_done && last_info[6]);
  c_slverr: cover property (pready && pslverr);
endmodule
bind rrw_top rrw_top_chk rrw_top_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cmd_valid(cmd_valid), .cmd(cmd), .tx_status_valid(tx_status_valid), .tx_status(tx_status),
  .tx_status_bad(tx_status_bad), .word_valid(word_valid), .word(word), .gap_seen(gap_seen),
  .extra_activity(extra_activity), .msg_end(msg_end), .record_done(record_done), .last_info(last_info));

/* bench/rrw_far_end.sv */
// Purpose: model of the bus decoder feeding the record writer
// Assumes: one task at a time, entered right after a clock edge
// Notes: released cmd, tx_status and word show the inverse of their last value; strobes and events drop to zero
`timescale 1ns/100ps
module rrw_far_end (
  // clock
  input wire logic pclk,
  // command and transmitter status
  output rrw_pkg::rrw_cmd_t cmd,
  output logic cmd_valid,
  output logic [15:0] tx_status,
  output logic tx_status_valid,
  output logic tx_status_bad,
  // data words and bus events
  output rrw_pkg::rrw_word_t word,
  output logic word_valid,
  output logic gap_seen,
  output logic extra_activity,
  output logic msg_end
);
  import rrw_pkg::*;
  // quiet bus at time zero
  initial begin
    cmd = '0;
    {cmd_valid, tx_status_valid, tx_status_bad, word_valid} = 4'h0;
    {gap_seen, extra_activity, msg_end} = 3'h0;
    tx_status = 16'h0;
    word = '0;
  end
  // validated command, one cycle
  task send_cmd(input rrw_cmd_t c);
    cmd <= c;
    cmd_valid <= 1'b1;
    @(posedge pclk);
    cmd <= ~c;
    cmd_valid <= 1'b0;
    @(posedge pclk);
  endtask
  // transmitter status word, bad marks parity or manchester fault
  task send_status(input logic [15:0] st, input logic bad);
    tx_status <= st;
    tx_status_bad <= bad;
    tx_status_valid <= 1'b1;
    @(posedge pclk);
    tx_status <= ~st;
    tx_status_valid <= 1'b0;
    @(posedge pclk);
  endtask
  // one received data word
  task send_word(input logic [15:0] d, input logic sync, input logic bad);
    word <= {d, sync, bad};
    word_valid <= 1'b1;
    @(posedge pclk);
    word <= ~{d, sync, bad};
    word_valid <= 1'b0;
    @(posedge pclk);
  endtask
  // bus event pulse: gap, extra activity, end
  task send_evt(input logic [2:0] e);
    {gap_seen, extra_activity, msg_end} <= e;
    @(posedge pclk);
    {gap_seen, extra_activity, msg_end} <= 3'h0;
    @(posedge pclk);
  endtask
endmodule

/* bench/rrw_top_test.sv */
// Purpose: self-checking bench of the record writer
// Assumes: rrw_far_end drives the decoder side
// Notes: the time-tag word is checked against a local edge count
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module rrw_top_test;
  import rrw_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, cmd_valid, tx_status_valid, tx_status_bad, word_valid;
  logic gap_seen, extra_activity, msg_end, record_done;
  logic [15:0] tx_status, last_info;
  rrw_cmd_t cmd;
  rrw_word_t word;
  int mismatches = 0, tests_run = 0;
  logic [15:0] tt, tag_exp;  // tag model and its value at validation
  logic [15:0] mem [int];  // data words the model knows
  always #2.5 pclk = ~pclk;
  // tag model: edges since reset, taken when a command is validated
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) tt <= 16'h0000;
    else tt <= tt + 16'h0001;
    if (presetn && cmd_valid) tag_exp <= tt;
  end
  rrw_top rrw_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_valid(cmd_valid), .cmd(cmd), .tx_status_valid(tx_status_valid), .tx_status(tx_status),
    .tx_status_bad(tx_status_bad), .word_valid(word_valid), .word(word), .gap_seen(gap_seen),
    .extra_activity(extra_activity), .msg_end(msg_end), .record_done(record_done), .last_info(last_info));
  rrw_far_end rrw_far_end_i (.pclk(pclk), .cmd(cmd), .cmd_valid(cmd_valid), .tx_status(tx_status),
    .tx_status_valid(tx_status_valid), .tx_status_bad(tx_status_bad), .word(word), .word_valid(word_valid),
    .gap_seen(gap_seen), .extra_activity(extra_activity), .msg_end(msg_end));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one apb transfer, held until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    `CHK(n < 50, 1'b1)
  endtask
  // read one ram word
  task rd(input int a, output logic [15:0] v);
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'(12'h800 + 4 * a), 32'h0, r, e);
    v = r[15:0];
  endtask
  task results;
    $display("tests %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    logic [31:0] r, s;
    logic e, bsep, gb;
    int kind, n, ns, base, to;
    logic [15:0] x, mask, v;
    rrw_cmd_t c;
    logic [15:0] q [$];
    s = 32'hc421;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0, r, e);
    `CHK(r[3:0], 4'h0)
    apb(1'b0, 12'h00c, 32'h0, r, e);
    `CHK(e, 1'b1)
    apb(1'b1, 12'h004, 32'h1, r, e);
    `CHK(e, 1'b1)
    $display("register test done");
    // eleven message kinds: clean, faults, broadcast, rt-rt
    for (int k = 0; k < 22; k++) begin
      kind = k % 11;
      s = lfsr(s);
      bsep = s[7];
      gb = s[6] & (kind < 5);
      apb(1'b1, 12'h000, {28'h0, gb, 2'b00, bsep}, r, e);
      n = (k == 11) ? 32 : s[1:0] + 1;
      c = '0;
      c.first_command_word = {5'h05, 1'b0, 5'h03, 5'(n)};
      c.second_command_word = {(kind == 8 && k > 10) ? 5'h1f : 5'h09, !(kind == 8 && k < 11), 5'h02, 5'(n)};
      c.rt_to_rt = kind > 6;
      c.broadcast = kind == 5 || kind == 6;
      c.bus_b = s[2];
      c.illegal = s[3];
      c.make_busy_control = s[4] & (kind < 5);
      c.buf_mode = rrw_buf_t'({kind == 6, s[5]});
      c.data_pointer = 9'h040;
      c.bcast_pointer = 9'h080;  // 34-word broadcast buffer
      base = (c.broadcast && bsep && !c.buf_mode[1]) ? 'h80 : 'h40;
      rrw_far_end_i.send_cmd(c);
      if (kind > 6 && kind < 10) rrw_far_end_i.send_status({c.second_command_word[15:11], 11'h0}, kind == 9);
      ns = (kind == 3) ? n - 1 : n;
      q.delete();
      for (int i = 0; i < ns && kind != 10; i++) begin
        s = lfsr(s);
        q.push_back(s[15:0]);
        rrw_far_end_i.send_word(s[15:0], kind == 2 && i == 0, kind == 1 && i == ns - 1);
      end
      if (kind == 4) rrw_far_end_i.send_evt(3'b010);
      if (kind != 10) rrw_far_end_i.send_evt(3'b001);
      to = 0;
      while (record_done !== 1'b1 && to < 4000) begin
        @(posedge pclk);
        to++;
      end
      `CHK(to < 4000, 1'b1)
      x = {kind == 10, kind == 1, kind == 4, kind == 3, kind == 2, 1'b0, gb | c.make_busy_control, c.illegal,
        kind == 8 || kind == 9, 1'b0, c.bus_b, 5'(n)};
      x[10] = |x[15:11] | x[7];
      x[6] = c.rt_to_rt & !x[10];
      mask = (kind == 10) ? 16'h8440 : 16'hffff;
      // faulted records leave the data area untouched
      if (!x[10]) foreach (q[i]) mem[base + 2 + i] = q[i];
      rd(base, v);
      `CHK(v & mask, x & mask)
      `CHK(last_info & mask, x & mask)
      rd(base + 1, v);
      `CHK(v, tag_exp)
      foreach (mem[a]) begin
        rd(a, v);
        `CHK(v, mem[a])
      end
      $display("message %0d kind %0d done", k, kind);
    end
    results();
  end
  // watchdog
  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    results();
  end
endmodule
